// ==== logic/bcd_bank_c_ctrl.sv ====
// Bank C output divider, power-down and configuration source control
`timescale 1ns/1ps
module bcd_bank_c_ctrl
    import bcd_pkg::*;
(
    input  wire logic       ref_clk_i,
    input  wire logic       reset_i,
    input  wire logic [1:0] bank_c_select_i,
    input  wire logic       init_clk_i,
    input  wire logic [7:0] reg_addr_i,
    input  wire logic [7:0] reg_wdata_i,
    input  wire logic       reg_wr_i,
    input  wire logic       reg_rd_i,
    output logic      [7:0] reg_rdata_o,
    output logic      [1:0] bank_c_output_o,
    output logic      [1:0] bank_c_output_run_o,
    output logic      [7:0] bank_c_ratio_o
);

    // ==========================================================
    // Ratio decode
    // Reserved codes give zero, which the init logic reads as keep the old ratio
    function automatic logic [7:0] bcd_ratio(input logic [5:0] code);
        logic [7:0] r;
        r = 8'h00;
        case (code)
            6'h02: r = 8'd2;
            6'h03: r = 8'd3;
            6'h04: r = 8'd4;
            6'h05: r = 8'd5;
            6'h06: r = 8'd6;
            6'h07: r = 8'd8;
            6'h08: r = 8'd9;
            6'h09: r = 8'd10;
            6'h0A: r = 8'd12;
            6'h0B: r = 8'd14;
            6'h0C: r = 8'd15;
            6'h0D: r = 8'd16;
            6'h0E: r = 8'd18;
            6'h0F: r = 8'd20;
            6'h10: r = 8'd21;
            6'h11: r = 8'd22;
            6'h12: r = 8'd24;
            6'h13: r = 8'd25;
            6'h14: r = 8'd27;
            6'h15: r = 8'd28;
            6'h16: r = 8'd30;
            6'h17: r = 8'd32;
            6'h18: r = 8'd33;
            6'h19: r = 8'd35;
            6'h1A: r = 8'd36;
            6'h1B: r = 8'd40;
            6'h1C: r = 8'd42;
            6'h1D: r = 8'd44;
            6'h1E: r = 8'd45;
            6'h1F: r = 8'd48;
            6'h20: r = 8'd50;
            6'h21: r = 8'd54;
            6'h22: r = 8'd55;
            6'h23: r = 8'd56;
            6'h24: r = 8'd60;
            6'h25: r = 8'd64;
            6'h26: r = 8'd66;
            6'h27: r = 8'd70;
            6'h28: r = 8'd72;
            6'h29: r = 8'd80;
            6'h2A: r = 8'd84;
            6'h2B: r = 8'd88;
            6'h2C: r = 8'd90;
            6'h2D: r = 8'd96;
            6'h2E: r = 8'd100;
            6'h2F: r = 8'd108;
            6'h30: r = 8'd110;
            6'h31: r = 8'd112;
            6'h32: r = 8'd120;
            6'h33: r = 8'd128;
            6'h34: r = 8'd132;
            6'h35: r = 8'd140;
            6'h36: r = 8'd144;
            6'h37: r = 8'd160;
            6'h38: r = 8'd176;
            6'h39: r = 8'd180;
            6'h3A: r = 8'd200;
            6'h3B: r = 8'd220;
            default: r = 8'h00;
        endcase
        return r;
    endfunction : bcd_ratio

    // ==========================================================
    // State
    typedef struct packed {
        logic [5:0] div_code;
        logic       bank_pd;
        logic       src;
        logic [1:0] out_pd;
        logic [7:0] ratio;
        logic [7:0] cnt;
        logic       init_prev;
        logic [1:0] outs;
        logic [1:0] run;
        logic [7:0] rdata;
    } bcd_state_type;

    bcd_state_type state;
    bcd_state_type next_state;

    // ==========================================================
    // Effective settings
    logic [5:0] eff_code;
    logic       eff_pd;
    logic [7:0] eff_ratio;
    logic [7:0] next_cnt;
    logic       phase;

    // ==========================================================
    // Next-state logic
    always_comb begin
        next_state = state;
        // Pins or registers steer the bank
        if (state.src) begin
            eff_code = state.div_code;
            eff_pd   = state.bank_pd;
        end else begin
            // Pin value 3 stops the bank and takes the pin 0 ratio code, which an init toggle still loads
            case (bank_c_select_i)
                2'h0:    eff_code = BCD_PIN_CODE0;
                2'h1:    eff_code = BCD_PIN_CODE1;
                2'h2:    eff_code = BCD_PIN_CODE2;
                default: eff_code = BCD_PIN_CODE0;
            endcase
            eff_pd = (bank_c_select_i == BCD_PIN_PD);
        end
        eff_ratio = bcd_ratio(eff_code);

        // Register writes; reserved bits are dropped
        // Writes to unknown addresses fall through and change nothing
        if (reg_wr_i) begin
            case (reg_addr_i)
                BCD_ADDR_DIV: next_state.div_code = reg_wdata_i[5:0];
                BCD_ADDR_CTRL: begin
                    next_state.bank_pd = reg_wdata_i[BCD_CTRL_PD_BIT];
                    next_state.src     = reg_wdata_i[BCD_CTRL_SRC_BIT];
                end
                BCD_ADDR_OPD0: next_state.out_pd[0] = reg_wdata_i[BCD_OPD_BIT];
                BCD_ADDR_OPD1: next_state.out_pd[1] = reg_wdata_i[BCD_OPD_BIT];
                default: ;
            endcase
        end

        // Reserved bits read as zero
        // Read data holds until the next read strobe
        if (reg_rd_i) begin
            case (reg_addr_i)
                BCD_ADDR_DIV:  next_state.rdata = {2'h0, state.div_code};
                BCD_ADDR_CTRL: next_state.rdata = {state.bank_pd, 6'h00, state.src};
                BCD_ADDR_OPD0: next_state.rdata = {state.out_pd[0], 7'h00};
                BCD_ADDR_OPD1: next_state.rdata = {state.out_pd[1], 7'h00};
                default:       next_state.rdata = 8'h00;
            endcase
        end

        // Ratio only moves on an init toggle; reserved codes keep the old ratio
        next_state.init_prev = init_clk_i;
        if ((init_clk_i != state.init_prev) && (eff_ratio != 8'h00)) begin
            next_state.ratio = eff_ratio;
        end

        // Counter parks at zero while the bank is down, so it restarts in phase
        // Divider: high for the first half of each period, odd ratios run short high
        if (eff_pd || (state.cnt >= state.ratio - 8'h01)) begin
            next_cnt = 8'h00;
        end else begin
            next_cnt = state.cnt + 8'h01;
        end
        phase          = next_cnt < {1'b0, state.ratio[7:1]};
        next_state.cnt = next_cnt;

        for (int i = 0; i < BCD_OUTS; i++) begin
            next_state.run[i]  = !eff_pd && !state.out_pd[i];
            next_state.outs[i] = next_state.run[i] && phase;
        end
    end

    // ==========================================================
    // State register
    // Synchronous reset; configuration and ratio reset values come from the package, all other fields clear to zero
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            state           <= '0;
            state.div_code  <= BCD_DIV_RESET;
            state.bank_pd   <= BCD_PD_RESET;
            state.src       <= BCD_SRC_RESET;
            state.out_pd    <= {BCD_OPD_RESET, BCD_OPD_RESET};
            state.ratio     <= BCD_RATIO_RESET;
            state.init_prev <= 1'b0;
        end else begin
            state <= next_state;
        end
    end

    // ==========================================================
    // Outputs, all straight from the state register
    assign reg_rdata_o         = state.rdata;
    assign bank_c_output_o     = state.outs;
    assign bank_c_output_run_o = state.run;
    assign bank_c_ratio_o      = state.ratio;

endmodule : bcd_bank_c_ctrl

// ==== logic/bcd_pkg.sv ====
// Constants for the bank C divider control block
package bcd_pkg;
    // ==========================================================
    // Register map (byte addresses of the bank C block)
    localparam logic [7:0] BCD_ADDR_DIV    = 8'h20;
    localparam logic [7:0] BCD_ADDR_CTRL   = 8'h22;
    localparam logic [7:0] BCD_ADDR_OPD0   = 8'h24;
    localparam logic [7:0] BCD_ADDR_OPD1   = 8'h25;
    // ==========================================================
    // Field positions
    localparam int BCD_CTRL_PD_BIT  = 7;
    localparam int BCD_CTRL_SRC_BIT = 0;
    localparam int BCD_OPD_BIT      = 7;
    // ==========================================================
    // Reset values
    localparam logic [5:0] BCD_DIV_RESET   = 6'h0D;
    localparam logic [7:0] BCD_RATIO_RESET = 8'h10;
    localparam logic       BCD_PD_RESET    = 1'b0;
    localparam logic       BCD_SRC_RESET   = 1'b0;
    localparam logic       BCD_OPD_RESET   = 1'b0;
    // ==========================================================
    // Select pin decode: pin values 0..2 pick a ratio code, 3 powers the bank down
    localparam logic [5:0] BCD_PIN_CODE0 = 6'h0D;
    localparam logic [5:0] BCD_PIN_CODE1 = 6'h09;
    localparam logic [5:0] BCD_PIN_CODE2 = 6'h07;
    localparam logic [1:0] BCD_PIN_PD    = 2'h3;
    localparam int         BCD_OUTS      = 2;
endpackage : bcd_pkg

// ==== verif/bcd_host_model.sv ====
// Processor model driving the bank C register bus
`timescale 1ns/1ps
module bcd_host_model
    import bcd_pkg::*;
(
    input  wire logic       ref_clk_i,
    output logic      [7:0] addr_o,
    output logic      [7:0] wdata_o,
    output logic            wr_o,
    output logic            rd_o,
    input  wire logic [7:0] rdata_i
);
    initial {addr_o, wdata_o, wr_o, rd_o} = '0;
    // Released address and data lines show inverted junk, never the last value; both strobes drop to zero
    task automatic acc(input logic [7:0] a, d, input logic w, output logic [7:0] q);
        @(posedge ref_clk_i) #1;
        {addr_o, wr_o, rd_o} = {a, w, !w};
        wdata_o = d & (a == BCD_ADDR_DIV ? 8'h3F : a == BCD_ADDR_CTRL ? 8'h81 : 8'h80);
        @(posedge ref_clk_i) #1;
        {addr_o, wdata_o, wr_o, rd_o} = {~a, ~wdata_o, 2'b00};
        @(posedge ref_clk_i) #1;
        q = rdata_i;
    endtask : acc
endmodule : bcd_host_model

// ==== verif/bcd_bank_c_ctrl_chk.sv ====
// Assertions on the bank C control ports
`timescale 1ns/1ps
module bcd_bank_c_ctrl_chk
    import bcd_pkg::*;
(
    input wire logic       ref_clk_i,
    input wire logic       reset_i,
    input wire logic [1:0] bank_c_select_i,
    input wire logic       init_clk_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic       reg_wr_i,
    input wire logic [1:0] bank_c_output_o,
    input wire logic [1:0] bank_c_output_run_o,
    input wire logic [7:0] bank_c_ratio_o
);
    logic src, pd, opd0, init_prev, tog_seen, tog;
    assign tog = init_clk_i != init_prev;
    always_ff @(posedge ref_clk_i) begin
        {init_prev, tog_seen} <= {init_clk_i, tog};
        if (reset_i) {src, pd, opd0} <= 3'h0;
        else if (reg_wr_i && reg_addr_i == BCD_ADDR_CTRL) {pd, src} <= {reg_wdata_i[7], reg_wdata_i[0]};
        else if (reg_wr_i && reg_addr_i == BCD_ADDR_OPD0) opd0 <= reg_wdata_i[7];
    end
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (reset_i);
    sequence up_s; (!opd0 && !(src ? pd : bank_c_select_i == BCD_PIN_PD)) [*3]; endsequence
    sequence down_s; (src ? pd : bank_c_select_i == BCD_PIN_PD) [*3]; endsequence
    sequence reg_on_s; (src && !pd && !opd0 && bank_c_select_i == BCD_PIN_PD) [*3]; endsequence
    a_reset_ratio: assert property ($fell(reset_i) |-> bank_c_ratio_o == BCD_RATIO_RESET)
        else $error("ratio reset");
    a_run_up: assert property (up_s |-> bank_c_output_run_o[0]) else $error("output stopped");
    a_bank_down: assert property (down_s |-> bank_c_output_run_o == 2'h0)
        else $error("bank running");
    a_out_down: assert property (reg_wr_i && reg_addr_i == BCD_ADDR_OPD1 && reg_wdata_i[7]
        |-> ##2 !bank_c_output_run_o[1]) else $error("output running");
    a_stop_low: assert property ((bank_c_output_o & ~bank_c_output_run_o) == 2'h0)
        else $error("clock while stopped");
    a_ratio_hold: assert property ($changed(bank_c_ratio_o) |-> tog_seen) else $error("no toggle");
    a_pin_ratio: assert property ((!src && bank_c_select_i == 2'h2) [*3] ##0 tog
        |=> bank_c_ratio_o == 8'h08) else $error("pin ratio");
    a_src_reg: assert property (reg_on_s |-> bank_c_output_run_o[0])
        else $error("register source");
endmodule : bcd_bank_c_ctrl_chk
bind bcd_bank_c_ctrl bcd_bank_c_ctrl_chk bcd_bank_c_ctrl_chk_inst (.ref_clk_i, .reset_i, .bank_c_select_i,
    .init_clk_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .bank_c_output_o, .bank_c_output_run_o, .bank_c_ratio_o);

// ==== verif/tb_top.sv ====
// Self-checking bench for the bank C divider control
`timescale 1ns/1ps
module tb_top
    import bcd_pkg::*;
;
    logic       ref_clk_i = 1'b0, reset_i = 1'b1, init = 1'b0, wen, ren;
    logic [1:0] sel = 2'h0, outc, run;
    logic [7:0] addr, wdata, rdata, ratio, q;
    int         error_cnt = 0, comparisons = 0;
    always #5 ref_clk_i = ~ref_clk_i;
    bcd_host_model bcd_host_model_inst (.ref_clk_i, .addr_o(addr), .wdata_o(wdata), .wr_o(wen), .rd_o(ren),
        .rdata_i(rdata));
    bcd_bank_c_ctrl bcd_bank_c_ctrl_inst (.ref_clk_i, .reset_i, .bank_c_select_i(sel), .init_clk_i(init),
        .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wen), .reg_rd_i(ren), .reg_rdata_o(rdata),
        .bank_c_output_o(outc), .bank_c_output_run_o(run), .bank_c_ratio_o(ratio));
    task automatic chk(input string n, input logic [7:0] e, g);
        comparisons++;
        error_cnt += int'(g !== e);
        if (g !== e)
            $display("unexpected %s expected %h seen %h", n, e, g);
    endtask : chk
    task automatic wr_reg(input logic [7:0] a, d);
        bcd_host_model_inst.acc(a, d, 1'b1, q);
    endtask : wr_reg
    // Reserved read bits are masked off, though the design reads them as zero
    task automatic rdc(input string n, input logic [7:0] a, m, e);
        bcd_host_model_inst.acc(a, 8'h00, 1'b0, q);
        chk(n, e, q & m);
    endtask : rdc
    task automatic flip();
        repeat (2) @(posedge ref_clk_i) #1;
        init = ~init;
        repeat (3) @(posedge ref_clk_i) #1;
    endtask : flip
    // High cycles over four periods check the duty on both outputs
    task automatic per(input logic [7:0] n);
        int h = 0;
        int h1 = 0;
        repeat (4 * n) begin
            @(posedge ref_clk_i) #1;
            h += int'(outc[0]);
            h1 += int'(outc[1]);
        end
        chk("high cycles", 8'(4 * (n / 2)), 8'(h));
        chk("high cycles 1", 8'(4 * (n / 2)), 8'(h1));
    endtask : per
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : wrap_up
    initial begin
        repeat (8) @(posedge ref_clk_i) #1;
        reset_i = 1'b0;
        repeat (2) @(posedge ref_clk_i) #1;
        chk("ratio", 8'h10, ratio);
        chk("run", 8'h03, 8'(run));
        rdc("ctrl", BCD_ADDR_CTRL, 8'h81, 8'h00);
        per(8'h10);
        sel = 2'h1;
        flip();
        chk("ratio", 8'h0A, ratio);
        sel = 2'h2;
        flip();
        chk("ratio", 8'h08, ratio);
        per(8'h08);
        sel = 2'h3;
        repeat (3) @(posedge ref_clk_i) #1;
        chk("run", 8'h00, 8'(run));
        $display("pin test done");
        wr_reg(BCD_ADDR_DIV, 8'h0C);
        wr_reg(BCD_ADDR_CTRL, 8'h01);
        chk("ratio", 8'h08, ratio);
        chk("run", 8'h03, 8'(run));
        flip();
        chk("ratio", 8'h0F, ratio);
        per(8'h0F);
        wr_reg(BCD_ADDR_DIV, 8'h3C);
        flip();
        chk("ratio", 8'h0F, ratio);
        wr_reg(8'h23, 8'hFF);
        rdc("ctrl", BCD_ADDR_CTRL, 8'h81, 8'h01);
        wr_reg(BCD_ADDR_OPD1, 8'h80);
        chk("run", 8'h01, 8'(run));
        wr_reg(BCD_ADDR_CTRL, 8'h81);
        wr_reg(BCD_ADDR_OPD0, 8'h80);
        chk("run", 8'h00, 8'(run));
        $display("register test done");
        wrap_up();
    end
    initial begin
        #50000;
        error_cnt++;
        wrap_up();
    end
endmodule : tb_top
